// ### include/dispatch_stall_regs.svh
// Timing-free sizing constants for the dispatch and retire stall logic.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DISPATCH_STALL_REGS_SVH
`define DISPATCH_STALL_REGS_SVH
`define CNT_W 4
`define RQ_DEPTH 4'h6
`define INT_RENAMES 4'h6
`define FLT_RENAMES 4'h6
`define INFLIGHT_MAX 5'h0c
`define RETIRE_WR_MAX 3'h2
`endif

// ### include/dispatch_stall_pkg.sv
// Types shared by the dispatch and retire stall logic.
// Assumes the sizing header sits on the include path.
`include "dispatch_stall_regs.svh"
package dispatch_stall_pkg;
  // Execution unit class needed by an instruction
  typedef enum logic [2:0]
  {
    UNIT_NONE,
    UNIT_INT,
    UNIT_FLOAT,
    UNIT_LOADSTORE,
    UNIT_SYSREG,
    UNIT_BRANCH
  } unit_class_type;
  // Kind of branch being resolved
  typedef enum logic [2:0]
  {
    BR_PLAIN,
    BR_TO_LINK,
    BR_TO_COUNT,
    BR_COUNT_COND,
    BR_COND
  } branch_kind_type;
  // Whole state of the stall block
  typedef struct packed
  {
    logic [`CNT_W-1:0] rq_cnt;
    logic [`CNT_W-1:0] int_used;
    logic [`CNT_W-1:0] flt_used;
    logic [`CNT_W-1:0] cser_cnt;
    logic [`CNT_W-1:0] sys_cnt;
    logic disp0;
    logic disp1;
    logic ret0;
    logic ret1;
    logic br_stall;
    logic fetch_hold;
    logic sys_hold;
    logic flush;
    logic refetch;
  } state_type;
endpackage

// ### verilog/dispatch_completion_stall_logic.sv
// Dispatch, retire and branch-resolution stall control for a two-wide core.
// Assumes queue entry fields are valid each cycle and counts fit in 4 bits.
//
// Overview of operation
// - Oldest dispatch needs free unit and renames
// - Oldest holds on full queue or serialization
// - Second dispatches only with oldest; two max
// - No second after serialized oldest instruction
// - Second judged after oldest's consumption
// - Oldest retires finished, unshadowed, exception-free
// - Second retires only with the oldest
// - Second also finished, unshadowed, exception-free
// - Second retires only integer or load
// - Dual retire writes at most two each
// - Retire queue holds six entries
// - Six integer renames; stall when exhausted
// - Load with update takes two renames
// - Six float renames in flight
// - At most twelve instructions in flight
// - Stall fetch without link or count
// - Linking branch needs free shadow link
// - Count-and-condition branch needs count or false
// - Condition branch waits for prior resolution
// - Hold system-register results until retirement
// - Mispredict flushes younger, refetch next cycle
`timescale 1ns/1ps
`include "dispatch_stall_regs.svh"
module dispatch_completion_stall_logic
#(
  parameter logic [3:0] RQ_DEPTH = `RQ_DEPTH,
  parameter logic [3:0] INT_RENAMES = `INT_RENAMES,
  parameter logic [3:0] FLT_RENAMES = `FLT_RENAMES
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic DQ0_VALID,
  input wire dispatch_stall_pkg::unit_class_type DQ0_UNIT,
  input wire logic DQ0_INT_DEST,
  input wire logic DQ0_LOAD_UPD,
  input wire logic DQ0_FLT_DEST,
  input wire logic DQ0_CSER,
  input wire logic DQ0_RSER,
  input wire logic DQ1_VALID,
  input wire dispatch_stall_pkg::unit_class_type DQ1_UNIT,
  input wire logic DQ1_INT_DEST,
  input wire logic DQ1_LOAD_UPD,
  input wire logic DQ1_FLT_DEST,
  input wire logic DQ1_CSER,
  input wire logic [5:0] UNIT_FREE,
  input wire logic INT2_FREE,
  input wire logic [3:0] IQ_COUNT,
  input wire logic RQ0_DONE,
  input wire logic RQ0_BEHIND,
  input wire logic RQ0_EXC,
  input wire logic RQ0_CSER,
  input wire logic RQ0_SYS,
  input wire logic [1:0] RQ0_CR_WR,
  input wire logic [1:0] RQ0_INT_WR,
  input wire logic [1:0] RQ0_FLT_WR,
  input wire logic RQ1_DONE,
  input wire logic RQ1_BEHIND,
  input wire logic RQ1_EXC,
  input wire logic RQ1_CSER,
  input wire logic RQ1_SYS,
  input wire logic RQ1_INT_OR_LOAD,
  input wire logic [1:0] RQ1_CR_WR,
  input wire logic [1:0] RQ1_INT_WR,
  input wire logic [1:0] RQ1_FLT_WR,
  input wire logic BR_VALID,
  input wire dispatch_stall_pkg::branch_kind_type BR_KIND,
  input wire logic BR_SETS_LINK,
  input wire logic LINK_AVAIL,
  input wire logic SHADOW_LINK_AVAIL,
  input wire logic COUNT_AVAIL,
  input wire logic COND_FALSE,
  input wire logic PRIOR_UNRESOLVED,
  input wire logic MISPREDICT,
  input wire logic [3:0] KEEP_RQ,
  input wire logic [3:0] KEEP_INT,
  input wire logic [3:0] KEEP_FLT,
  input wire logic [3:0] KEEP_CSER,
  input wire logic [3:0] KEEP_SYS,
  output logic DISPATCH0,
  output logic DISPATCH1,
  output logic RETIRE0,
  output logic RETIRE1,
  output logic BRANCH_STALL,
  output logic FETCH_HOLD,
  output logic SYSREG_HOLD,
  output logic FLUSH,
  output logic REFETCH
);
  import dispatch_stall_pkg::*;

  state_type st_reg;
  state_type st_next;

  // Unit check; a second integer instruction may use the second integer unit
  function automatic logic unit_ok(input unit_class_type cls, input logic [5:0] free,
                                   input logic int2, input unit_class_type taken_cls,
                                   input logic taken);
    logic clash;
    clash = taken && (taken_cls == cls) && (cls != UNIT_NONE);
    if (cls == UNIT_NONE)
      unit_ok = 1'b1;
    else if (clash)
      unit_ok = (cls == UNIT_INT) && int2;
    else
      unit_ok = free[cls];
  endfunction

  // Widen a one-bit or two-bit count to counter width
  function automatic logic [3:0] w4(input logic [1:0] v);
    w4 = {2'h0, v};
  endfunction

  // Next-state computation for decisions and occupancy counters
  always_comb
  begin
    logic d0;
    logic d1;
    logic r0;
    logic r1;
    logic [3:0] need_i0;
    logic [3:0] need_i1;
    logic [3:0] need_f0;
    logic [3:0] need_f1;
    logic [3:0] free_i;
    logic [3:0] free_f;
    logic [3:0] add_rq;
    logic [3:0] sub_rq;
    logic [4:0] inflight;
    d0 = 1'b0;
    d1 = 1'b0;
    r0 = 1'b0;
    r1 = 1'b0;
    st_next = st_reg;
    need_i0 = w4({1'b0, DQ0_INT_DEST}) + w4({1'b0, DQ0_LOAD_UPD});
    need_i1 = w4({1'b0, DQ1_INT_DEST}) + w4({1'b0, DQ1_LOAD_UPD});
    need_f0 = w4({1'b0, DQ0_FLT_DEST});
    need_f1 = w4({1'b0, DQ1_FLT_DEST});
    // Oldest entry: unit, renames, queue space, no serializer in flight
    d0 = DQ0_VALID && !MISPREDICT && !st_reg.flush
      && unit_ok(DQ0_UNIT, UNIT_FREE, INT2_FREE, UNIT_NONE, 1'b0)
      && (st_reg.int_used + need_i0 <= INT_RENAMES)
      && (st_reg.flt_used + need_f0 <= FLT_RENAMES)
      && (st_reg.rq_cnt < RQ_DEPTH)
      && (st_reg.cser_cnt == 4'h0);
    // Second entry is judged net of what the oldest takes this cycle
    d1 = d0 && DQ1_VALID && !DQ0_CSER && !DQ0_RSER
      && unit_ok(DQ1_UNIT, UNIT_FREE, INT2_FREE, DQ0_UNIT, 1'b1)
      && (st_reg.int_used + need_i0 + need_i1 <= INT_RENAMES)
      && (st_reg.flt_used + need_f0 + need_f1 <= FLT_RENAMES)
      && (st_reg.rq_cnt + 4'h1 < RQ_DEPTH);
    // Retirement is oldest first; the second slot never goes alone
    r0 = !MISPREDICT && (st_reg.rq_cnt != 4'h0)
      && RQ0_DONE && !RQ0_BEHIND && !RQ0_EXC;
    r1 = r0 && (st_reg.rq_cnt >= 4'h2)
      && RQ1_DONE && !RQ1_BEHIND && !RQ1_EXC
      && RQ1_INT_OR_LOAD
      && ({1'b0, RQ0_CR_WR} + {1'b0, RQ1_CR_WR} <= `RETIRE_WR_MAX)
      && ({1'b0, RQ0_INT_WR} + {1'b0, RQ1_INT_WR} <= `RETIRE_WR_MAX)
      && ({1'b0, RQ0_FLT_WR} + {1'b0, RQ1_FLT_WR} <= `RETIRE_WR_MAX);
    free_i = (r0 ? w4(RQ0_INT_WR) : 4'h0) + (r1 ? w4(RQ1_INT_WR) : 4'h0);
    free_f = (r0 ? w4(RQ0_FLT_WR) : 4'h0) + (r1 ? w4(RQ1_FLT_WR) : 4'h0);
    add_rq = w4({1'b0, d0}) + w4({1'b0, d1});
    sub_rq = w4({1'b0, r0}) + w4({1'b0, r1});
    st_next.rq_cnt = st_reg.rq_cnt + add_rq - sub_rq;
    st_next.int_used = st_reg.int_used - free_i
      + (d0 ? need_i0 : 4'h0) + (d1 ? need_i1 : 4'h0);
    st_next.flt_used = st_reg.flt_used - free_f
      + (d0 ? need_f0 : 4'h0) + (d1 ? need_f1 : 4'h0);
    st_next.cser_cnt = st_reg.cser_cnt
      + w4({1'b0, d0 && DQ0_CSER}) + w4({1'b0, d1 && DQ1_CSER})
      - w4({1'b0, r0 && RQ0_CSER}) - w4({1'b0, r1 && RQ1_CSER});
    // System-register results stay hidden until the producer retires
    st_next.sys_cnt = st_reg.sys_cnt
      + w4({1'b0, d0 && DQ0_UNIT == UNIT_SYSREG})
      + w4({1'b0, d1 && DQ1_UNIT == UNIT_SYSREG})
      - w4({1'b0, r0 && RQ0_SYS}) - w4({1'b0, r1 && RQ1_SYS});
    st_next.sys_hold = (st_next.sys_cnt != 4'h0);
    // Mispredict: younger work and its renames are dropped by the keep counts
    if (MISPREDICT)
    begin
      st_next.rq_cnt = KEEP_RQ;
      st_next.int_used = KEEP_INT;
      st_next.flt_used = KEEP_FLT;
      st_next.cser_cnt = KEEP_CSER;
      st_next.sys_cnt = KEEP_SYS;
      st_next.sys_hold = (KEEP_SYS != 4'h0);
    end
    st_next.flush = MISPREDICT;
    st_next.refetch = st_reg.flush;
    st_next.disp0 = d0;
    st_next.disp1 = d1;
    st_next.ret0 = r0;
    st_next.ret1 = r1;
    // Capacity check uses both queues; retiring this cycle is not credited
    inflight = {1'b0, IQ_COUNT} + {1'b0, st_reg.rq_cnt};
    st_next.fetch_hold = (inflight >= `INFLIGHT_MAX);
    // Branch resolution resources
    st_next.br_stall = 1'b0;
    if (BR_VALID)
    begin
      case (BR_KIND)
        BR_TO_LINK: st_next.br_stall = !LINK_AVAIL;
        BR_TO_COUNT: st_next.br_stall = !COUNT_AVAIL;
        BR_COUNT_COND: st_next.br_stall = (!COUNT_AVAIL && !COND_FALSE)
          || PRIOR_UNRESOLVED;
        BR_COND: st_next.br_stall = PRIOR_UNRESOLVED;
        default: st_next.br_stall = 1'b0;
      endcase
      if (BR_SETS_LINK && !SHADOW_LINK_AVAIL)
        st_next.br_stall = 1'b1;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state flops
  assign DISPATCH0 = st_reg.disp0;
  assign DISPATCH1 = st_reg.disp1;
  assign RETIRE0 = st_reg.ret0;
  assign RETIRE1 = st_reg.ret1;
  assign BRANCH_STALL = st_reg.br_stall;
  assign FETCH_HOLD = st_reg.fetch_hold;
  assign SYSREG_HOLD = st_reg.sys_hold;
  assign FLUSH = st_reg.flush;
  assign REFETCH = st_reg.refetch;

  // Checks on the registered decisions against the inputs that caused them
  property p_oldest_room;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.disp0 |-> $past(st_reg.rq_cnt) < RQ_DEPTH && $past(st_reg.cser_cnt) == 4'h0;
  endproperty
  a_oldest_room: assert property (p_oldest_room) else $error("oldest dispatched without room");
  property p_pair_dispatch;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.disp1 |-> st_reg.disp0 && !$past(DQ0_CSER) && !$past(DQ0_RSER);
  endproperty
  a_pair_dispatch: assert property (p_pair_dispatch) else $error("bad second dispatch");
  // The pair must leave room for both entries in the retire queue
  property p_pair_room;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.disp1 |-> $past(st_reg.rq_cnt) + 4'h2 <= RQ_DEPTH;
  endproperty
  a_pair_room: assert property (p_pair_room) else $error("pair dispatched without room");
  property p_pair_retire;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.ret1 |-> st_reg.ret0 && $past(RQ1_DONE && !RQ1_EXC && RQ1_INT_OR_LOAD);
  endproperty
  a_pair_retire: assert property (p_pair_retire) else $error("bad second retire");
  property p_oldest_retire;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.ret0 |-> $past(RQ0_DONE && !RQ0_BEHIND && !RQ0_EXC);
  endproperty
  a_oldest_retire: assert property (p_oldest_retire) else $error("bad oldest retire");
  property p_write_limit;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.ret1 |-> $past({1'b0, RQ0_INT_WR} + {1'b0, RQ1_INT_WR}) <= 3'h2
      && $past({1'b0, RQ0_CR_WR} + {1'b0, RQ1_CR_WR}) <= 3'h2
      && $past({1'b0, RQ0_FLT_WR} + {1'b0, RQ1_FLT_WR}) <= 3'h2;
  endproperty
  a_write_limit: assert property (p_write_limit) else $error("too many writes retired");
  property p_bounds;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.rq_cnt <= RQ_DEPTH && st_reg.int_used <= INT_RENAMES
      && st_reg.flt_used <= FLT_RENAMES;
  endproperty
  a_bounds: assert property (p_bounds) else $error("occupancy over limit");
  property p_link_stall;
    @(posedge CLK_SYS) disable iff (!RST_N)
    BR_VALID && BR_KIND == BR_TO_LINK && !LINK_AVAIL |=> st_reg.br_stall;
  endproperty
  a_link_stall: assert property (p_link_stall) else $error("missed link stall");
  // A linking branch of any kind waits for a free shadow copy
  property p_shadow_stall;
    @(posedge CLK_SYS) disable iff (!RST_N)
    BR_VALID && BR_SETS_LINK && !SHADOW_LINK_AVAIL |=> st_reg.br_stall;
  endproperty
  a_shadow_stall: assert property (p_shadow_stall) else $error("missed shadow link stall");
  property p_count_cond;
    @(posedge CLK_SYS) disable iff (!RST_N)
    BR_VALID && BR_KIND == BR_COUNT_COND && !COUNT_AVAIL && !COND_FALSE |=> st_reg.br_stall;
  endproperty
  a_count_cond: assert property (p_count_cond) else $error("missed count stall");
  property p_refetch;
    @(posedge CLK_SYS) disable iff (!RST_N)
    MISPREDICT |=> st_reg.flush && !st_reg.disp0 ##1 st_reg.refetch;
  endproperty
  a_refetch: assert property (p_refetch) else $error("refetch not one cycle after flush");
  property p_inflight;
    @(posedge CLK_SYS) disable iff (!RST_N)
    st_reg.fetch_hold == ($past({1'b0, IQ_COUNT} + {1'b0, st_reg.rq_cnt}) >= 5'h0c);
  endproperty
  a_inflight: assert property (p_inflight) else $error("fetch hold wrong");
  c_dual_dispatch: cover property (@(posedge CLK_SYS) st_reg.disp1);
  c_dual_retire: cover property (@(posedge CLK_SYS) st_reg.ret1);
  c_flush: cover property (@(posedge CLK_SYS) st_reg.flush ##1 st_reg.refetch);
  c_br_stall: cover property (@(posedge CLK_SYS) st_reg.br_stall);
  c_fetch_hold: cover property (@(posedge CLK_SYS) st_reg.fetch_hold);
endmodule

// ### sim/dispatch_completion_stall_logic_test.sv
// Self-checking bench for the dispatch, retire and branch stall block.
// Assumes the package is compiled first; counters are preset through flush pulses.
`timescale 1ns/1ps
module dispatch_completion_stall_logic_test;
  import dispatch_stall_pkg::*;
  logic CLK_SYS = 1'h0, RST_N = 1'h0, INT2_FREE = 1'h1, MISPREDICT = 1'h0;
  logic DQ0_VALID = 1'h0, DQ0_INT_DEST = 1'h0, DQ0_LOAD_UPD = 1'h0, DQ0_FLT_DEST = 1'h0;
  logic DQ0_CSER = 1'h0, DQ0_RSER = 1'h0, DQ1_VALID = 1'h0, DQ1_INT_DEST = 1'h0;
  logic DQ1_LOAD_UPD = 1'h0, DQ1_FLT_DEST = 1'h0, DQ1_CSER = 1'h0;
  unit_class_type DQ0_UNIT = UNIT_INT, DQ1_UNIT = UNIT_INT;
  logic [5:0] UNIT_FREE = 6'h3f;
  logic [3:0] IQ_COUNT = 4'h0, KEEP_RQ = 4'h0, KEEP_INT = 4'h0, KEEP_FLT = 4'h0;
  logic [3:0] KEEP_CSER = 4'h0, KEEP_SYS = 4'h0;
  logic RQ0_DONE = 1'h0, RQ0_BEHIND = 1'h0, RQ0_EXC = 1'h0, RQ0_CSER = 1'h0, RQ0_SYS = 1'h0;
  logic RQ1_DONE = 1'h0, RQ1_BEHIND = 1'h0, RQ1_EXC = 1'h0, RQ1_CSER = 1'h0, RQ1_SYS = 1'h0;
  logic RQ1_INT_OR_LOAD = 1'h0;
  logic [1:0] RQ0_CR_WR = 2'h0, RQ0_INT_WR = 2'h0, RQ0_FLT_WR = 2'h0;
  logic [1:0] RQ1_CR_WR = 2'h0, RQ1_INT_WR = 2'h0, RQ1_FLT_WR = 2'h0;
  logic BR_VALID = 1'h0, BR_SETS_LINK = 1'h0, LINK_AVAIL = 1'h1, SHADOW_LINK_AVAIL = 1'h1;
  logic COUNT_AVAIL = 1'h1, COND_FALSE = 1'h0, PRIOR_UNRESOLVED = 1'h0;
  branch_kind_type BR_KIND = BR_PLAIN;
  logic DISPATCH0, DISPATCH1, RETIRE0, RETIRE1, BRANCH_STALL, FETCH_HOLD;
  logic SYSREG_HOLD, FLUSH, REFETCH;
  int bad_count = 0, samples_checked = 0, cycles = 0;

  dispatch_completion_stall_logic i_dispatch_completion_stall_logic
  (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .DQ0_VALID(DQ0_VALID), .DQ0_UNIT(DQ0_UNIT),
    .DQ0_INT_DEST(DQ0_INT_DEST), .DQ0_LOAD_UPD(DQ0_LOAD_UPD), .DQ0_FLT_DEST(DQ0_FLT_DEST),
    .DQ0_CSER(DQ0_CSER), .DQ0_RSER(DQ0_RSER), .DQ1_VALID(DQ1_VALID), .DQ1_UNIT(DQ1_UNIT),
    .DQ1_INT_DEST(DQ1_INT_DEST), .DQ1_LOAD_UPD(DQ1_LOAD_UPD), .DQ1_FLT_DEST(DQ1_FLT_DEST),
    .DQ1_CSER(DQ1_CSER), .UNIT_FREE(UNIT_FREE), .INT2_FREE(INT2_FREE), .IQ_COUNT(IQ_COUNT),
    .RQ0_DONE(RQ0_DONE), .RQ0_BEHIND(RQ0_BEHIND), .RQ0_EXC(RQ0_EXC), .RQ0_CSER(RQ0_CSER),
    .RQ0_SYS(RQ0_SYS), .RQ0_CR_WR(RQ0_CR_WR), .RQ0_INT_WR(RQ0_INT_WR), .RQ0_FLT_WR(RQ0_FLT_WR),
    .RQ1_DONE(RQ1_DONE), .RQ1_BEHIND(RQ1_BEHIND), .RQ1_EXC(RQ1_EXC), .RQ1_CSER(RQ1_CSER),
    .RQ1_SYS(RQ1_SYS), .RQ1_INT_OR_LOAD(RQ1_INT_OR_LOAD), .RQ1_CR_WR(RQ1_CR_WR),
    .RQ1_INT_WR(RQ1_INT_WR), .RQ1_FLT_WR(RQ1_FLT_WR), .BR_VALID(BR_VALID), .BR_KIND(BR_KIND),
    .BR_SETS_LINK(BR_SETS_LINK), .LINK_AVAIL(LINK_AVAIL), .SHADOW_LINK_AVAIL(SHADOW_LINK_AVAIL),
    .COUNT_AVAIL(COUNT_AVAIL), .COND_FALSE(COND_FALSE), .PRIOR_UNRESOLVED(PRIOR_UNRESOLVED),
    .MISPREDICT(MISPREDICT), .KEEP_RQ(KEEP_RQ), .KEEP_INT(KEEP_INT), .KEEP_FLT(KEEP_FLT),
    .KEEP_CSER(KEEP_CSER), .KEEP_SYS(KEEP_SYS), .DISPATCH0(DISPATCH0), .DISPATCH1(DISPATCH1),
    .RETIRE0(RETIRE0), .RETIRE1(RETIRE1), .BRANCH_STALL(BRANCH_STALL), .FETCH_HOLD(FETCH_HOLD),
    .SYSREG_HOLD(SYSREG_HOLD), .FLUSH(FLUSH), .REFETCH(REFETCH)
  );

  // Core clock, 4 ns period
  always #2 CLK_SYS = ~CLK_SYS;

  // Cycle ceiling; the whole run needs under two hundred cycles
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task chk(input string name, input logic seen, input logic exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        bad_count++;
      end
    end
  endtask

  // Let the block sample the staged inputs, then withdraw the requests
  task step;
    begin
      @(posedge CLK_SYS);
      {DQ0_VALID, DQ1_VALID, BR_VALID, MISPREDICT, RQ0_DONE, RQ1_DONE} <= 6'h0;
      #1;
    end
  endtask

  // A flush loads known counts; a dispatch offered meanwhile must be refused
  task set_counts(input logic [3:0] rq, iu, fu, cs, sy);
    begin
      @(posedge CLK_SYS);
      {KEEP_RQ, KEEP_INT, KEEP_FLT, KEEP_CSER, KEEP_SYS} <= {rq, iu, fu, cs, sy};
      {MISPREDICT, DQ0_VALID} <= 2'h3;
      {DQ0_INT_DEST, DQ0_LOAD_UPD, DQ0_FLT_DEST, DQ0_CSER, DQ0_RSER} <= 5'h0;
      {DQ1_INT_DEST, DQ1_LOAD_UPD, DQ1_FLT_DEST, DQ1_CSER} <= 4'h0;
      {RQ0_BEHIND, RQ0_EXC, RQ0_SYS, RQ1_BEHIND, RQ1_EXC, RQ1_INT_OR_LOAD} <= 6'h0;
      {RQ0_CR_WR, RQ0_INT_WR, RQ0_FLT_WR, RQ1_CR_WR, RQ1_INT_WR, RQ1_FLT_WR} <= 12'h0;
      UNIT_FREE <= 6'h3f;
      step;
      chk("FLUSH", FLUSH, 1'h1);
      chk("DISPATCH0", DISPATCH0, 1'h0);
      @(posedge CLK_SYS);
      #1;
      chk("REFETCH", REFETCH, 1'h1);
      chk("FLUSH", FLUSH, 1'h0);
    end
  endtask

  // Counts packed rq/int/flt/cser; f0 dest/upd/flt/cser/rser; f1 valid/dest/upd/flt/cser
  task dcase(input logic [15:0] c, input logic [4:0] f0, f1, input unit_class_type u0, u1,
             input logic [5:0] free, input logic [1:0] e);
    begin
      set_counts(c[15:12], c[11:8], c[7:4], c[3:0], 4'h0);
      @(posedge CLK_SYS);
      DQ0_VALID <= 1'h1;
      {DQ0_INT_DEST, DQ0_LOAD_UPD, DQ0_FLT_DEST, DQ0_CSER, DQ0_RSER} <= f0;
      {DQ1_VALID, DQ1_INT_DEST, DQ1_LOAD_UPD, DQ1_FLT_DEST, DQ1_CSER} <= f1;
      DQ0_UNIT <= u0;
      DQ1_UNIT <= u1;
      UNIT_FREE <= free;
      step;
      chk("DISPATCH0", DISPATCH0, e[1]);
      chk("DISPATCH1", DISPATCH1, e[0]);
    end
  endtask

  // f: done0 behind0 exc0 done1 behind1 exc1 intload; w: cond/int/float write counts
  task rcase(input logic [3:0] rq, input logic [6:0] f, input logic [5:0] w0, w1,
             input logic [1:0] e);
    begin
      set_counts(rq, 4'h3, 4'h3, 4'h0, 4'h0);
      @(posedge CLK_SYS);
      {RQ0_DONE, RQ0_BEHIND, RQ0_EXC, RQ1_DONE, RQ1_BEHIND, RQ1_EXC, RQ1_INT_OR_LOAD} <= f;
      {RQ0_CR_WR, RQ0_INT_WR, RQ0_FLT_WR, RQ1_CR_WR, RQ1_INT_WR, RQ1_FLT_WR} <= {w0, w1};
      step;
      chk("RETIRE0", RETIRE0, e[1]);
      chk("RETIRE1", RETIRE1, e[0]);
    end
  endtask

  // f: link, shadow link, sets link, count, condition false, prior unresolved
  task bcase(input branch_kind_type k, input logic [5:0] f, input logic e);
    begin
      @(posedge CLK_SYS);
      BR_VALID <= 1'h1;
      BR_KIND <= k;
      {LINK_AVAIL, SHADOW_LINK_AVAIL, BR_SETS_LINK, COUNT_AVAIL, COND_FALSE,
       PRIOR_UNRESOLVED} <= f;
      step;
      chk("BRANCH_STALL", BRANCH_STALL, e);
    end
  endtask

  // In-flight limit and withheld system-register result released by retirement
  task t_hold;
    begin
      set_counts(4'h6, 4'h0, 4'h0, 4'h1, 4'h1);
      @(posedge CLK_SYS);
      IQ_COUNT <= 4'h6;
      @(posedge CLK_SYS);
      IQ_COUNT <= 4'h5;
      #1;
      chk("FETCH_HOLD", FETCH_HOLD, 1'h1);
      chk("SYSREG_HOLD", SYSREG_HOLD, 1'h1);
      @(posedge CLK_SYS);
      {RQ0_DONE, RQ0_SYS, IQ_COUNT} <= 6'h30;
      RQ0_CSER <= 1'h1;
      #1;
      chk("FETCH_HOLD", FETCH_HOLD, 1'h0);
      step;
      @(posedge CLK_SYS);
      #1;
      chk("SYSREG_HOLD", SYSREG_HOLD, 1'h0);
      // The serializer has retired, so the oldest entry may go again
      @(posedge CLK_SYS);
      DQ0_VALID <= 1'h1;
      step;
      chk("DISPATCH0", DISPATCH0, 1'h1);
    end
  endtask

  initial
  begin
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'h1;
    @(posedge CLK_SYS);
    #1;
    chk("DISPATCH0", DISPATCH0, 1'h0);
    dcase(16'h0000, 5'h10, 5'h18, UNIT_INT, UNIT_LOADSTORE, 6'h3f, 2'h3);
    dcase(16'h0000, 5'h00, 5'h10, UNIT_LOADSTORE, UNIT_INT, 6'h37, 2'h0);
    dcase(16'h0600, 5'h10, 5'h00, UNIT_INT, UNIT_INT, 6'h3f, 2'h0);
    dcase(16'h0500, 5'h18, 5'h00, UNIT_LOADSTORE, UNIT_INT, 6'h3f, 2'h0);
    dcase(16'h0400, 5'h18, 5'h00, UNIT_LOADSTORE, UNIT_INT, 6'h3f, 2'h2);
    dcase(16'h0060, 5'h04, 5'h00, UNIT_FLOAT, UNIT_INT, 6'h3f, 2'h0);
    dcase(16'h6000, 5'h00, 5'h00, UNIT_INT, UNIT_INT, 6'h3f, 2'h0);
    dcase(16'h0001, 5'h00, 5'h00, UNIT_INT, UNIT_INT, 6'h3f, 2'h0);
    dcase(16'h0000, 5'h01, 5'h10, UNIT_INT, UNIT_LOADSTORE, 6'h3f, 2'h2);
    dcase(16'h0000, 5'h02, 5'h10, UNIT_INT, UNIT_LOADSTORE, 6'h3f, 2'h2);
    dcase(16'h5000, 5'h00, 5'h10, UNIT_INT, UNIT_LOADSTORE, 6'h3f, 2'h2);
    dcase(16'h0500, 5'h10, 5'h18, UNIT_INT, UNIT_LOADSTORE, 6'h3f, 2'h2);
    dcase(16'h0050, 5'h04, 5'h12, UNIT_FLOAT, UNIT_LOADSTORE, 6'h3f, 2'h2);
    dcase(16'h0000, 5'h00, 5'h10, UNIT_FLOAT, UNIT_FLOAT, 6'h3f, 2'h2);
    dcase(16'h0000, 5'h10, 5'h18, UNIT_INT, UNIT_INT, 6'h3f, 2'h3);
    @(posedge CLK_SYS);
    INT2_FREE <= 1'h0;
    dcase(16'h0000, 5'h10, 5'h18, UNIT_INT, UNIT_INT, 6'h3f, 2'h2);
    rcase(4'h2, 7'h49, 6'h15, 6'h15, 2'h3);
    rcase(4'h2, 7'h59, 6'h00, 6'h00, 2'h0);
    rcase(4'h2, 7'h69, 6'h00, 6'h00, 2'h0);
    rcase(4'h2, 7'h09, 6'h00, 6'h00, 2'h0);
    rcase(4'h2, 7'h4d, 6'h00, 6'h00, 2'h2);
    rcase(4'h2, 7'h4b, 6'h00, 6'h00, 2'h2);
    rcase(4'h2, 7'h41, 6'h00, 6'h00, 2'h2);
    rcase(4'h2, 7'h48, 6'h00, 6'h00, 2'h2);
    rcase(4'h2, 7'h49, 6'h20, 6'h10, 2'h2);
    rcase(4'h2, 7'h49, 6'h08, 6'h04, 2'h2);
    rcase(4'h2, 7'h49, 6'h01, 6'h02, 2'h2);
    rcase(4'h1, 7'h49, 6'h00, 6'h00, 2'h2);
    bcase(BR_TO_LINK, 6'h14, 1'h1);
    bcase(BR_TO_LINK, 6'h34, 1'h0);
    bcase(BR_TO_COUNT, 6'h30, 1'h1);
    bcase(BR_PLAIN, 6'h2c, 1'h1);
    bcase(BR_PLAIN, 6'h3c, 1'h0);
    bcase(BR_COUNT_COND, 6'h30, 1'h1);
    bcase(BR_COUNT_COND, 6'h32, 1'h0);
    bcase(BR_COND, 6'h35, 1'h1);
    bcase(BR_COND, 6'h34, 1'h0);
    t_hold;
    end_sim();
  end
endmodule
